// ---- hdl/exec_cfg.svh ----
// constants for the skip/set/subtract/swap/table-read execution slice
// assumes one 8-bit data path and a program word wider than one byte
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define DMEM_DEPTH 88
`define DMEM_AW 7
`define ROM_AW 12
`define ROM_DW 15
`define BYTE_W 8
`define BIT_IDX_W 3
`define ALL_ONES_8 8'hFF
`define ZERO_8 8'h00
`define ONE_8 8'h01
`define HI_NIB 7:4
`define LO_NIB 3:0
`define NIB_W 4
`define SIGN_BIT 7
`endif

// ---- hdl/exec_pkg.sv ----
// types shared by the execution slice
// assumes the decode stage hands over one of these operation codes
package exec_pkg;
   typedef enum logic [4:0] {
      OP_NOP,
      OP_DEC_TO_ACC_SKIP_ZERO,
      OP_SET_MEM,
      OP_SET_BIT,
      OP_INC_MEM_SKIP_ZERO,
      OP_INC_TO_ACC_SKIP_ZERO,
      OP_SKIP_BIT_NONZERO,
      OP_SUBTRACT_ACC,
      OP_SUBTRACT_TO_MEMORY,
      OP_SUBTRACT_IMM,
      OP_SWAP_MEM,
      OP_NIBBLE_EXCHANGE_TO_ACC,
      OP_SKIP_MEM_ZERO,
      OP_COPY_ACC_SKIP_ZERO,
      OP_SKIP_BIT_ZERO,
      OP_TABLE_READ_CURRENT_PAGE,
      OP_TABLE_READ_LAST_PAGE,
      OP_XOR_ACC_MEM
   } op_e;
   typedef logic [7:0] byte_t;
endpackage

// ---- hdl/sub_unit.sv ----
// subtractor: a + ~b + 1 with overflow, zero, nibble carry and carry
// assumes operands arrive from logic on the same clock
`timescale 1ns/100ps
`include "exec_cfg.svh"
module sub_unit (
   input wire logic [`BYTE_W-1:0] a_i,
   input wire logic [`BYTE_W-1:0] b_i,
   output logic [`BYTE_W-1:0] res_o,
   output logic ov_o,
   output logic z_o,
   output logic ac_o,
   output logic c_o
);
   logic [`BYTE_W:0] full_w;
   logic [`NIB_W:0] low_w;
   // carry = no borrow, the usual sense for a + ~b + 1
   assign full_w = {1'b0, a_i} + {1'b0, ~b_i} + {{`BYTE_W{1'b0}}, 1'b1};
   assign low_w = {1'b0, a_i[`LO_NIB]} + {1'b0, ~b_i[`LO_NIB]} + {{`NIB_W{1'b0}}, 1'b1};
   assign res_o = full_w[`BYTE_W-1:0];
   assign c_o = full_w[`BYTE_W];
   assign ac_o = low_w[`NIB_W];
   assign z_o = (res_o == `ZERO_8);
   // signed overflow: equal signs into the adder, different sign out
   assign ov_o = (a_i[`SIGN_BIT] == ~b_i[`SIGN_BIT]) && (res_o[`SIGN_BIT] != a_i[`SIGN_BIT]);
endmodule

// ---- hdl/data_mem.sv ----
// data memory: one write port, two combinational read ports
// assumes addresses at or above the depth are unmapped
`timescale 1ns/100ps
`include "exec_cfg.svh"
module data_mem #(
   parameter int DEPTH = `DMEM_DEPTH,
   parameter int AW = `DMEM_AW
) (
   input wire logic clk_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [`BYTE_W-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_a_addr_i,
   output logic [`BYTE_W-1:0] rd_a_data_o,
   input wire logic [AW-1:0] rd_b_addr_i,
   output logic [`BYTE_W-1:0] rd_b_data_o
);
   logic [`BYTE_W-1:0] mem_q [DEPTH];
   // unmapped writes dropped, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end
   assign rd_a_data_o = (int'(rd_a_addr_i) < DEPTH) ? mem_q[rd_a_addr_i] : `ZERO_8;
   assign rd_b_data_o = (int'(rd_b_addr_i) < DEPTH) ? mem_q[rd_b_addr_i] : `ZERO_8;
endmodule

// ---- hdl/skip_set_sub_swap_table_exec.sv ----
// execution slice: skips, byte/bit set, subtracts, nibble swap, table reads, xor
// assumes decode, program memory and the other instructions sit on the same clock
`timescale 1ns/100ps
`include "exec_cfg.svh"
module skip_set_sub_swap_table_exec #(
   parameter int DMEM_DEPTH = `DMEM_DEPTH,
   parameter int AW = `DMEM_AW,
   parameter int ROM_AW = `ROM_AW,
   parameter int ROM_DW = `ROM_DW
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic instr_valid_i,
   input wire exec_pkg::op_e instr_op_i,
   input wire logic [AW-1:0] instr_addr_i,
   input wire logic [`BIT_IDX_W-1:0] instr_bit_i,
   input wire logic [`BYTE_W-1:0] instr_imm_i,
   input wire logic [ROM_AW-`BYTE_W-1:0] page_i,
   input wire logic table_pointer_wr_i,
   input wire logic [`BYTE_W-1:0] table_pointer_data_i,
   input wire logic acc_wr_i,
   input wire logic [`BYTE_W-1:0] acc_data_i,
   input wire logic flag_wr_i,
   input wire logic timeout_flag_i,
   input wire logic power_down_flag_i,
   input wire logic signed_range_flag_i,
   input wire logic zero_flag_i,
   input wire logic nibble_carry_flag_i,
   input wire logic carry_flag_i,
   input wire logic mem_wr_i,
   input wire logic [AW-1:0] mem_wr_addr_i,
   input wire logic [`BYTE_W-1:0] mem_wr_data_i,
   input wire logic [AW-1:0] dbg_addr_i,
   input wire logic [ROM_DW-1:0] rom_data_i,
   output logic ready_o,
   output logic discard_o,
   output logic retire_o,
   output logic [`BYTE_W-1:0] acc_o,
   output logic timeout_flag_o,
   output logic power_down_flag_o,
   output logic signed_range_flag_o,
   output logic zero_flag_o,
   output logic nibble_carry_flag_o,
   output logic carry_flag_o,
   output logic [`BYTE_W-1:0] table_pointer_o,
   output logic [ROM_DW-`BYTE_W-1:0] table_high_latch_o,
   output logic rom_rd_o,
   output logic [ROM_AW-1:0] rom_addr_o,
   output logic [`BYTE_W-1:0] dbg_data_o
);
   localparam int HIGH_W = ROM_DW - `BYTE_W;
   localparam int PAGE_W = ROM_AW - `BYTE_W;

   logic ready_q;
   logic discard_q;
   logic retire_q;
   logic [`BYTE_W-1:0] acc_q;
   logic to_q;
   logic pdf_q;
   logic ov_q;
   logic z_q;
   logic ac_q;
   logic c_q;
   logic [`BYTE_W-1:0] table_pointer_q;
   logic [HIGH_W-1:0] table_high_latch_q;
   logic rom_rd_q;
   logic [ROM_AW-1:0] rom_addr_q;
   logic [AW-1:0] pend_addr_q;
   logic [`BYTE_W-1:0] dbg_q;

   logic exec_w;
   logic [`BYTE_W-1:0] operand_w;
   logic [`BYTE_W-1:0] dbg_rd_w;
   logic [`BYTE_W-1:0] dec_w;
   logic [`BYTE_W-1:0] inc_w;
   logic [`BYTE_W-1:0] swap_w;
   logic [`BYTE_W-1:0] mask_w;
   logic [`BYTE_W-1:0] xor_w;
   logic bit_w;
   logic [`BYTE_W-1:0] sub_b_w;
   logic [`BYTE_W-1:0] sub_res_w;
   logic sub_ov_w;
   logic sub_z_w;
   logic sub_ac_w;
   logic sub_c_w;

   logic acc_we_w;
   logic [`BYTE_W-1:0] acc_nx_w;
   logic mem_we_w;
   logic [`BYTE_W-1:0] mem_wd_w;
   logic skip_w;
   logic arith_we_w;
   logic zero_we_w;
   logic table_w;
   logic last_page_w;

   logic dm_we_w;
   logic [AW-1:0] dm_wa_w;
   logic [`BYTE_W-1:0] dm_wd_w;

   // the cycle after a taken skip only swallows the prefetched word
   assign exec_w = instr_valid_i && ready_q && !discard_q;

   assign dec_w = operand_w - `ONE_8;
   assign inc_w = operand_w + `ONE_8;
   assign swap_w = {operand_w[`LO_NIB], operand_w[`HI_NIB]};
   assign mask_w = `ONE_8 << instr_bit_i;
   assign bit_w = operand_w[instr_bit_i];
   assign xor_w = acc_q ^ operand_w;
   assign sub_b_w = (instr_op_i == exec_pkg::OP_SUBTRACT_IMM) ? instr_imm_i : operand_w;

   sub_unit u_sub (
      .a_i(acc_q),
      .b_i(sub_b_w),
      .res_o(sub_res_w),
      .ov_o(sub_ov_w),
      .z_o(sub_z_w),
      .ac_o(sub_ac_w),
      .c_o(sub_c_w)
   );

   // execution writes and table writes never meet: table data lands while ready is low
   assign dm_we_w = mem_we_w || rom_rd_q || mem_wr_i;
   assign dm_wa_w = mem_we_w ? instr_addr_i : (rom_rd_q ? pend_addr_q : mem_wr_addr_i);
   assign dm_wd_w = mem_we_w ? mem_wd_w : (rom_rd_q ? rom_data_i[`BYTE_W-1:0] : mem_wr_data_i);

   data_mem #(
      .DEPTH(DMEM_DEPTH),
      .AW(AW)
   ) u_mem (
      .clk_i(clk_i),
      .wr_en_i(dm_we_w),
      .wr_addr_i(dm_wa_w),
      .wr_data_i(dm_wd_w),
      .rd_a_addr_i(instr_addr_i),
      .rd_a_data_o(operand_w),
      .rd_b_addr_i(dbg_addr_i),
      .rd_b_data_o(dbg_rd_w)
   );

   always_comb begin
      acc_we_w = 1'b0;
      acc_nx_w = acc_q;
      mem_we_w = 1'b0;
      mem_wd_w = operand_w;
      skip_w = 1'b0;
      arith_we_w = 1'b0;
      zero_we_w = 1'b0;
      table_w = 1'b0;
      last_page_w = 1'b0;
      if (exec_w) begin
         unique case (instr_op_i)
            exec_pkg::OP_NOP: begin
               acc_nx_w = acc_q;
            end
            exec_pkg::OP_DEC_TO_ACC_SKIP_ZERO: begin
               acc_we_w = 1'b1;
               acc_nx_w = dec_w;
               skip_w = (dec_w == `ZERO_8);
            end
            exec_pkg::OP_SET_MEM: begin
               mem_we_w = 1'b1;
               mem_wd_w = `ALL_ONES_8;
            end
            exec_pkg::OP_SET_BIT: begin
               mem_we_w = 1'b1;
               mem_wd_w = operand_w | mask_w;
            end
            exec_pkg::OP_INC_MEM_SKIP_ZERO: begin
               mem_we_w = 1'b1;
               mem_wd_w = inc_w;
               skip_w = (inc_w == `ZERO_8);
            end
            exec_pkg::OP_INC_TO_ACC_SKIP_ZERO: begin
               acc_we_w = 1'b1;
               acc_nx_w = inc_w;
               skip_w = (inc_w == `ZERO_8);
            end
            exec_pkg::OP_SKIP_BIT_NONZERO: begin
               skip_w = bit_w;
            end
            exec_pkg::OP_SUBTRACT_ACC, exec_pkg::OP_SUBTRACT_IMM: begin
               acc_we_w = 1'b1;
               acc_nx_w = sub_res_w;
               arith_we_w = 1'b1;
            end
            exec_pkg::OP_SUBTRACT_TO_MEMORY: begin
               mem_we_w = 1'b1;
               mem_wd_w = sub_res_w;
               arith_we_w = 1'b1;
            end
            exec_pkg::OP_SWAP_MEM: begin
               mem_we_w = 1'b1;
               mem_wd_w = swap_w;
            end
            exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: begin
               acc_we_w = 1'b1;
               acc_nx_w = swap_w;
            end
            exec_pkg::OP_SKIP_MEM_ZERO: begin
               skip_w = (operand_w == `ZERO_8);
            end
            exec_pkg::OP_COPY_ACC_SKIP_ZERO: begin
               acc_we_w = 1'b1;
               acc_nx_w = operand_w;
               skip_w = (operand_w == `ZERO_8);
            end
            exec_pkg::OP_SKIP_BIT_ZERO: begin
               skip_w = !bit_w;
            end
            exec_pkg::OP_TABLE_READ_CURRENT_PAGE: begin
               table_w = 1'b1;
            end
            exec_pkg::OP_TABLE_READ_LAST_PAGE: begin
               table_w = 1'b1;
               last_page_w = 1'b1;
            end
            exec_pkg::OP_XOR_ACC_MEM: begin
               acc_we_w = 1'b1;
               acc_nx_w = xor_w;
               zero_we_w = 1'b1;
            end
            default: begin
               acc_nx_w = acc_q;
            end
         endcase
      end
   end

   // skip and dummy-cycle control
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         discard_q <= 1'b0;
      end else begin
         discard_q <= skip_w;
      end
   end

   // table read holds the pipe one extra cycle while the word comes back
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ready_q <= 1'b0;
         rom_rd_q <= 1'b0;
         rom_addr_q <= '0;
         pend_addr_q <= '0;
      end else begin
         rom_rd_q <= table_w;
         ready_q <= !table_w;
         if (table_w) begin
            rom_addr_q <= {(last_page_w ? {PAGE_W{1'b1}} : page_i), table_pointer_q};
            pend_addr_q <= instr_addr_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         table_high_latch_q <= '0;
      end else if (rom_rd_q) begin
         table_high_latch_q <= rom_data_i[ROM_DW-1:`BYTE_W];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         table_pointer_q <= `ZERO_8;
      end else if (table_pointer_wr_i) begin
         table_pointer_q <= table_pointer_data_i;
      end
   end

   // an executing instruction that writes the accumulator wins over the outside accumulator write
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_q <= `ZERO_8;
      end else if (acc_we_w) begin
         acc_q <= acc_nx_w;
      end else if (acc_wr_i) begin
         acc_q <= acc_data_i;
      end
   end

   // only subtract and xor touch flags here; all other ops leave them
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ov_q <= 1'b0;
         z_q <= 1'b0;
         ac_q <= 1'b0;
         c_q <= 1'b0;
         to_q <= 1'b0;
         pdf_q <= 1'b0;
      end else if (arith_we_w) begin
         ov_q <= sub_ov_w;
         z_q <= sub_z_w;
         ac_q <= sub_ac_w;
         c_q <= sub_c_w;
      end else if (zero_we_w) begin
         z_q <= (xor_w == `ZERO_8);
      end else if (flag_wr_i && !exec_w) begin
         ov_q <= signed_range_flag_i;
         z_q <= zero_flag_i;
         ac_q <= nibble_carry_flag_i;
         c_q <= carry_flag_i;
         to_q <= timeout_flag_i;
         pdf_q <= power_down_flag_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         retire_q <= 1'b0;
         dbg_q <= `ZERO_8;
      end else begin
         retire_q <= (exec_w && !table_w) || rom_rd_q;
         dbg_q <= dbg_rd_w;
      end
   end

   assign ready_o = ready_q;
   assign discard_o = discard_q;
   assign retire_o = retire_q;
   assign acc_o = acc_q;
   assign timeout_flag_o = to_q;
   assign power_down_flag_o = pdf_q;
   assign signed_range_flag_o = ov_q;
   assign zero_flag_o = z_q;
   assign nibble_carry_flag_o = ac_q;
   assign carry_flag_o = c_q;
   assign table_pointer_o = table_pointer_q;
   assign table_high_latch_o = table_high_latch_q;
   assign rom_rd_o = rom_rd_q;
   assign rom_addr_o = rom_addr_q;
   assign dbg_data_o = dbg_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_dec_acc_skip:
   assert property (exec_w && instr_op_i == exec_pkg::OP_DEC_TO_ACC_SKIP_ZERO
      |=> acc_o == $past(operand_w) - `ONE_8 && discard_o == ($past(operand_w) == `ONE_8))
      else $error("decrement to acc wrong");

   a_skip_dummy_cycle:
   assert property (exec_w && skip_w |=> discard_o && retire_o ##1 !discard_o && !retire_o)
      else $error("taken skip did not insert one dummy cycle");

   a_no_skip_single:
   assert property (exec_w && !skip_w && !table_w |=> !discard_o && ready_o)
      else $error("unskipped instruction stalled");

   a_set_byte_ones:
   assert property (exec_w && instr_op_i == exec_pkg::OP_SET_MEM
      |-> dm_we_w && dm_wd_w == `ALL_ONES_8 ##1 $stable({ov_q, z_q, ac_q, c_q}))
      else $error("byte set wrong");

   a_set_bit_only:
   assert property (exec_w && instr_op_i == exec_pkg::OP_SET_BIT
      |-> dm_wd_w[instr_bit_i] && ((dm_wd_w ^ operand_w) & ~mask_w) == `ZERO_8)
      else $error("bit set touched other bits");

   a_inc_mem_skip:
   assert property (exec_w && instr_op_i == exec_pkg::OP_INC_MEM_SKIP_ZERO
      |-> dm_we_w && dm_wd_w == operand_w + `ONE_8 ##1 discard_o == ($past(operand_w) == `ALL_ONES_8))
      else $error("increment memory wrong");

   a_inc_acc_skip:
   assert property (exec_w && instr_op_i == exec_pkg::OP_INC_TO_ACC_SKIP_ZERO
      |-> !dm_we_w || mem_wr_i ##1 acc_o == $past(operand_w) + `ONE_8)
      else $error("increment to acc wrong");

   a_bit_skips:
   assert property (exec_w && (instr_op_i == exec_pkg::OP_SKIP_BIT_NONZERO
      || instr_op_i == exec_pkg::OP_SKIP_BIT_ZERO)
      |=> discard_o == ($past(bit_w) ^ ($past(instr_op_i) == exec_pkg::OP_SKIP_BIT_ZERO)))
      else $error("bit test skip wrong");

   a_sub_acc_flags:
   assert property (exec_w && (instr_op_i == exec_pkg::OP_SUBTRACT_ACC
      || instr_op_i == exec_pkg::OP_SUBTRACT_IMM)
      |=> acc_o == $past(acc_o) - $past(sub_b_w) && carry_flag_o == ($past(acc_o) >= $past(sub_b_w))
      && zero_flag_o == (acc_o == `ZERO_8))
      else $error("subtract to acc wrong");

   a_sub_mem_keep_acc:
   assert property (exec_w && instr_op_i == exec_pkg::OP_SUBTRACT_TO_MEMORY
      |-> dm_wd_w == acc_q - operand_w ##1 $stable(acc_o) && zero_flag_o == ($past(acc_o) == $past(operand_w)))
      else $error("subtract to memory wrong");

   a_swap_nibbles:
   assert property (exec_w && instr_op_i == exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC
      |=> acc_o[`HI_NIB] == $past(operand_w[`LO_NIB]) && acc_o[`LO_NIB] == $past(operand_w[`HI_NIB]))
      else $error("nibble exchange wrong");

   a_zero_skips:
   assert property (exec_w && (instr_op_i == exec_pkg::OP_SKIP_MEM_ZERO
      || instr_op_i == exec_pkg::OP_COPY_ACC_SKIP_ZERO)
      |=> discard_o == ($past(operand_w) == `ZERO_8))
      else $error("zero test skip wrong");

   a_table_read:
   assert property (exec_w && table_w |=> rom_rd_o && !ready_o
      && rom_addr_o[`BYTE_W-1:0] == table_pointer_o ##1 ready_o && retire_o
      && table_high_latch_o == $past(rom_data_i[ROM_DW-1:`BYTE_W]))
      else $error("table read sequence wrong");

   a_xor_zero_only:
   assert property (exec_w && instr_op_i == exec_pkg::OP_XOR_ACC_MEM
      |=> acc_o == ($past(acc_o) ^ $past(operand_w)) && zero_flag_o == (acc_o == `ZERO_8)
      && $stable({ov_q, ac_q, c_q}))
      else $error("xor result or flags wrong");

   a_flags_kept:
   assert property (exec_w && !arith_we_w && !zero_we_w
      |=> $stable({to_q, pdf_q, ov_q, z_q, ac_q, c_q}))
      else $error("flags changed by flag-neutral op");
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the skip/set/subtract/swap/table/xor execution slice
// assumes the slice runs alone: the bench plays decode, program memory and the rest of the core
`timescale 1ns/100ps
module testbench;
   localparam logic [6:0] poison = 7'h57;
   logic clk_i = 1'b0, rst_b_i = 1'b0, instr_valid_i = 1'b0, table_pointer_wr_i = 1'b0;
   logic acc_wr_i = 1'b0, flag_wr_i = 1'b0, mem_wr_i = 1'b0;
   logic timeout_flag_i = 1'b0, power_down_flag_i = 1'b0, signed_range_flag_i = 1'b0;
   logic zero_flag_i = 1'b0, nibble_carry_flag_i = 1'b0, carry_flag_i = 1'b0;
   exec_pkg::op_e instr_op_i = exec_pkg::OP_NOP;
   logic [6:0] instr_addr_i = 7'h00, mem_wr_addr_i = 7'h00, dbg_addr_i = 7'h00;
   logic [2:0] instr_bit_i = 3'h0;
   logic [7:0] instr_imm_i = 8'h00, table_pointer_data_i = 8'h00, acc_data_i = 8'h00, mem_wr_data_i = 8'h00;
   logic [3:0] page_i = 4'h0;
   logic [14:0] rom_data_i = 15'h0000;
   logic ready_o, discard_o, retire_o, rom_rd_o;
   logic timeout_flag_o, power_down_flag_o, signed_range_flag_o, zero_flag_o, nibble_carry_flag_o, carry_flag_o;
   logic [7:0] acc_o, table_pointer_o, dbg_data_o;
   logic [6:0] table_high_latch_o;
   logic [11:0] rom_addr_o;
   logic [5:0] flag_out;
   int err_total = 0, total_checks = 0;

   assign flag_out = {timeout_flag_o, power_down_flag_o, signed_range_flag_o, zero_flag_o,
                      nibble_carry_flag_o, carry_flag_o};

   always #4 clk_i = ~clk_i;

   skip_set_sub_swap_table_exec u_skip_set_sub_swap_table_exec (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
      .instr_addr_i(instr_addr_i), .instr_bit_i(instr_bit_i), .instr_imm_i(instr_imm_i), .page_i(page_i),
      .table_pointer_wr_i(table_pointer_wr_i), .table_pointer_data_i(table_pointer_data_i),
      .acc_wr_i(acc_wr_i), .acc_data_i(acc_data_i), .flag_wr_i(flag_wr_i), .timeout_flag_i(timeout_flag_i),
      .power_down_flag_i(power_down_flag_i), .signed_range_flag_i(signed_range_flag_i),
      .zero_flag_i(zero_flag_i), .nibble_carry_flag_i(nibble_carry_flag_i), .carry_flag_i(carry_flag_i),
      .mem_wr_i(mem_wr_i), .mem_wr_addr_i(mem_wr_addr_i), .mem_wr_data_i(mem_wr_data_i),
      .dbg_addr_i(dbg_addr_i), .rom_data_i(rom_data_i), .ready_o(ready_o), .discard_o(discard_o),
      .retire_o(retire_o), .acc_o(acc_o), .timeout_flag_o(timeout_flag_o),
      .power_down_flag_o(power_down_flag_o), .signed_range_flag_o(signed_range_flag_o),
      .zero_flag_o(zero_flag_o), .nibble_carry_flag_o(nibble_carry_flag_o), .carry_flag_o(carry_flag_o),
      .table_pointer_o(table_pointer_o), .table_high_latch_o(table_high_latch_o), .rom_rd_o(rom_rd_o),
      .rom_addr_o(rom_addr_o), .dbg_data_o(dbg_data_o)
   );

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic step();
      @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask

   task automatic mem_put(input logic [6:0] a, input logic [7:0] v);
      mem_wr_i = 1'b1;
      mem_wr_addr_i = a;
      mem_wr_data_i = v;
      step();
      mem_wr_i = 1'b0;
      // idle edge so a following put never re-raises the strobe in this time step
      step();
   endtask

   task automatic mem_get(input logic [6:0] a, output logic [7:0] v);
      dbg_addr_i = a;
      step();
      v = dbg_data_o;
   endtask

   task automatic load_acc(input logic [7:0] v);
      acc_wr_i = 1'b1;
      acc_data_i = v;
      step();
      acc_wr_i = 1'b0;
   endtask

   task automatic load_flags(input logic [5:0] f);
      flag_wr_i = 1'b1;
      {timeout_flag_i, power_down_flag_i, signed_range_flag_i, zero_flag_i, nibble_carry_flag_i,
       carry_flag_i} = f;
      step();
      flag_wr_i = 1'b0;
   endtask

   task automatic issue(input exec_pkg::op_e op, input logic [6:0] a, input logic [2:0] b,
                        input logic [7:0] imm);
      int n = 0;
      // valid is left high for the caller; an edge always passes before it is raised again
      do begin
         step();
         n++;
         if (n > 20) begin
            err_total++;
            $display("MISMATCH at %0t: ready never seen", $time);
            final_report();
         end
      end while (!(ready_o === 1'b1 && discard_o === 1'b0));
      instr_valid_i = 1'b1;
      instr_op_i = op;
      instr_addr_i = a;
      instr_bit_i = b;
      instr_imm_i = imm;
      step();
   endtask

   // a valid byte set on the poison address rides the dummy cycle and must be dropped
   task automatic run(input exec_pkg::op_e op, input logic [6:0] a, input logic skip,
                      input logic [2:0] b = 3'h0, input logic [7:0] imm = 8'h00);
      issue(op, a, b, imm);
      chk(retire_o, 1'b1, "retire");
      chk(discard_o, skip, "discard");
      if (skip) begin
         instr_op_i = exec_pkg::OP_SET_MEM;
         instr_addr_i = poison;
         step();
      end
      instr_valid_i = 1'b0;
      if (skip) begin
         chk(discard_o, 1'b0, "dummy length");
      end
   endtask

   function automatic logic [11:0] sub_exp(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, ~b} + 9'h001;
      h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      return {s[7:0], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
   endfunction

   task automatic t_dec_inc();
      logic [7:0] d;
      mem_put(poison, 8'h00);
      mem_put(7'h01, 8'h01);
      mem_put(7'h02, 8'h05);
      mem_put(7'h03, 8'hFF);
      mem_put(7'h04, 8'h7F);
      mem_put(7'h05, 8'hFF);
      load_flags(6'h2A);
      run(exec_pkg::OP_DEC_TO_ACC_SKIP_ZERO, 7'h01, 1'b1);
      chk(acc_o, 8'h00, "dec acc");
      run(exec_pkg::OP_DEC_TO_ACC_SKIP_ZERO, 7'h02, 1'b0);
      chk(acc_o, 8'h04, "dec acc");
      mem_get(7'h01, d);
      chk(d, 8'h01, "dec mem kept");
      run(exec_pkg::OP_INC_MEM_SKIP_ZERO, 7'h03, 1'b1);
      run(exec_pkg::OP_INC_MEM_SKIP_ZERO, 7'h04, 1'b0);
      mem_get(7'h03, d);
      chk(d, 8'h00, "inc mem");
      mem_get(7'h04, d);
      chk(d, 8'h80, "inc mem");
      run(exec_pkg::OP_INC_TO_ACC_SKIP_ZERO, 7'h04, 1'b0);
      chk(acc_o, 8'h81, "inc acc");
      run(exec_pkg::OP_INC_TO_ACC_SKIP_ZERO, 7'h05, 1'b1);
      chk(acc_o, 8'h00, "inc acc");
      mem_get(7'h05, d);
      chk(d, 8'hFF, "inc mem kept");
      chk(flag_out, 6'h2A, "flags kept");
      mem_get(poison, d);
      chk(d, 8'h00, "dummy dropped");
   endtask

   task automatic t_set_swap();
      logic [7:0] d;
      logic [7:0] e = 8'h24;
      load_flags(6'h15);
      mem_put(7'h10, 8'h00);
      mem_put(7'h11, 8'h24);
      mem_put(7'h12, 8'h3C);
      mem_put(7'h13, 8'hA5);
      run(exec_pkg::OP_SET_MEM, 7'h10, 1'b0);
      mem_get(7'h10, d);
      chk(d, 8'hFF, "byte set");
      for (int i = 0; i < 8; i++) begin
         run(exec_pkg::OP_SET_BIT, 7'h11, 1'b0, i[2:0]);
         e[i] = 1'b1;
         mem_get(7'h11, d);
         chk(d, e, "bit set");
      end
      run(exec_pkg::OP_SWAP_MEM, 7'h12, 1'b0);
      mem_get(7'h12, d);
      chk(d, 8'hC3, "swap mem");
      run(exec_pkg::OP_NIBBLE_EXCHANGE_TO_ACC, 7'h13, 1'b0);
      chk(acc_o, 8'h5A, "swap acc");
      mem_get(7'h13, d);
      chk(d, 8'hA5, "swap mem kept");
      chk(flag_out, 6'h15, "flags kept");
   endtask

   task automatic t_skips();
      logic [7:0] d;
      load_flags(6'h0A);
      mem_put(7'h20, 8'h04);
      mem_put(7'h21, 8'h00);
      run(exec_pkg::OP_SKIP_BIT_NONZERO, 7'h20, 1'b1, 3'h2);
      run(exec_pkg::OP_SKIP_BIT_NONZERO, 7'h20, 1'b0, 3'h3);
      run(exec_pkg::OP_SKIP_BIT_ZERO, 7'h20, 1'b0, 3'h2);
      run(exec_pkg::OP_SKIP_BIT_ZERO, 7'h20, 1'b1, 3'h7);
      run(exec_pkg::OP_SKIP_MEM_ZERO, 7'h20, 1'b0);
      run(exec_pkg::OP_SKIP_MEM_ZERO, 7'h21, 1'b1);
      run(exec_pkg::OP_COPY_ACC_SKIP_ZERO, 7'h20, 1'b0);
      chk(acc_o, 8'h04, "copy");
      run(exec_pkg::OP_COPY_ACC_SKIP_ZERO, 7'h21, 1'b1);
      chk(acc_o, 8'h00, "copy zero");
      mem_get(7'h20, d);
      chk(d, 8'h04, "mem kept");
      chk(flag_out, 6'h0A, "flags kept");
   endtask

   // the immediate form sees the inverse in memory, so a wrong operand source shows
   task automatic sub_case(input exec_pkg::op_e op, input logic [7:0] a, input logic [7:0] b);
      logic [11:0] e;
      logic [7:0] d;
      e = sub_exp(a, b);
      mem_put(7'h30, (op == exec_pkg::OP_SUBTRACT_IMM) ? ~b : b);
      load_acc(a);
      run(op, 7'h30, 1'b0, 3'h0, b);
      chk(flag_out, {2'b11, e[3:0]}, "sub flags");
      if (op == exec_pkg::OP_SUBTRACT_TO_MEMORY) begin
         chk(acc_o, a, "acc kept");
         mem_get(7'h30, d);
         chk(d, e[11:4], "sub mem");
      end else begin
         chk(acc_o, e[11:4], "sub acc");
      end
   endtask

   task automatic t_sub();
      load_flags(6'h30);
      sub_case(exec_pkg::OP_SUBTRACT_ACC, 8'h10, 8'h01);
      sub_case(exec_pkg::OP_SUBTRACT_ACC, 8'h01, 8'h02);
      sub_case(exec_pkg::OP_SUBTRACT_TO_MEMORY, 8'h05, 8'h05);
      sub_case(exec_pkg::OP_SUBTRACT_IMM, 8'h80, 8'h01);
      sub_case(exec_pkg::OP_SUBTRACT_IMM, 8'h7F, 8'hFF);
   endtask

   task automatic t_xor();
      load_flags(6'h2D);
      mem_put(7'h31, 8'h5A);
      load_acc(8'h0F);
      run(exec_pkg::OP_XOR_ACC_MEM, 7'h31, 1'b0);
      chk(acc_o, 8'h55, "xor");
      chk(flag_out, 6'h29, "xor flags");
      load_acc(8'h5A);
      run(exec_pkg::OP_XOR_ACC_MEM, 7'h31, 1'b0);
      chk(acc_o, 8'h00, "xor");
      chk(flag_out, 6'h2D, "xor flags");
   endtask

   task automatic tbl(input exec_pkg::op_e op, input logic [11:0] ra, input logic [14:0] w);
      logic [7:0] d;
      issue(op, 7'h40, 3'h0, 8'h00);
      instr_valid_i = 1'b0;
      rom_data_i = w;
      chk(rom_rd_o, 1'b1, "rom read");
      chk(rom_addr_o, ra, "rom addr");
      chk(ready_o, 1'b0, "ready in fetch");
      step();
      rom_data_i = ~w;
      chk(retire_o, 1'b1, "table retire");
      chk(table_high_latch_o, w[14:8], "table high");
      mem_get(7'h40, d);
      chk(d, w[7:0], "table low");
   endtask

   task automatic t_table();
      load_flags(6'h11);
      table_pointer_wr_i = 1'b1;
      table_pointer_data_i = 8'hA7;
      page_i = 4'h3;
      step();
      table_pointer_wr_i = 1'b0;
      chk(table_pointer_o, 8'hA7, "table pointer");
      tbl(exec_pkg::OP_TABLE_READ_CURRENT_PAGE, 12'h3A7, 15'h5A3C);
      tbl(exec_pkg::OP_TABLE_READ_LAST_PAGE, 12'hFA7, 15'h2BC1);
      chk(flag_out, 6'h11, "flags kept");
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      #1;
      chk(ready_o, 1'b0, "ready in reset");
      rst_b_i = 1'b1;
      step();
      step();
      t_dec_inc();
      t_set_swap();
      t_skips();
      t_sub();
      t_xor();
      t_table();
      final_report();
   end
endmodule
